// ### bench/rfd_ctrl_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Control bank stand-in: lower half of the index implemented
module rfd_ctrl_bank (
  input wire logic sys_clk,
  input wire logic ctrlWrEn,
  input wire logic [7:0] ctrlIdx,
  input wire logic [7:0] ctrlWrData,
  output logic [7:0] ctrlRdData,
  output logic ctrlImpl
);
  logic [7:0] mem [128];
  // Store implemented places only
  always_ff @(posedge sys_clk) begin
    if (ctrlWrEn && !ctrlIdx[7]) begin
      mem[ctrlIdx[6:0]] <= ctrlWrData;
    end
  end
  // Reserved slots show a moving pattern, so a stale byte never passes
  assign ctrlImpl = !ctrlIdx[7];
  assign ctrlRdData = ctrlImpl ? mem[ctrlIdx[6:0]] : ~ctrlIdx;
endmodule // rfd_ctrl_bank
`default_nettype wire

// ### bench/rfd_register_file_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rfd_register_file_bench;
  logic sys_clk = 0;
  logic srst = 1;
  rfd_pkg::rfd_req_type rfReq = '0;
  rfd_pkg::rfd_mem_req_type pmReq = '0;
  rfd_pkg::rfd_mem_req_type dmReq = '0;
  logic [11:0] corner [4] = '{12'h0ff, 12'h100, 12'heff, 12'hf00};
  logic [7:0] rfRdData_r, ctrlIdx, ctrlWrData, ctrlRdData;
  logic rfRdValid_r, ctrlSel, ctrlWrEn, ctrlRdEn, ctrlImpl, pmFlashSel;
  logic pmRdValid_r, pmInRange_r, dmSel, rfDropped_r;
  logic [15:0] pmFlashAddr, dmAddr;
  logic [7:0] shadow [4096];
  logic [11:0] a;
  logic [15:0] pa [5] = '{16'h0000, 16'h03ff, 16'h0400, 16'hffff, 16'h1234};
  int error_cnt = 0;
  int checks = 0;
  always #20 sys_clk = ~sys_clk;
  rfd_register_file #(.RAM_BYTES(256), .FLASH_BYTES(1024)) DUT (.sys_clk(sys_clk),
    .srst(srst), .rfReq(rfReq), .rfRdData_r(rfRdData_r), .rfRdValid_r(rfRdValid_r),
    .ctrlSel(ctrlSel), .ctrlWrEn(ctrlWrEn), .ctrlRdEn(ctrlRdEn), .ctrlIdx(ctrlIdx),
    .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData), .ctrlImpl(ctrlImpl), .pmReq(pmReq),
    .pmFlashSel(pmFlashSel), .pmFlashAddr(pmFlashAddr), .pmRdValid_r(pmRdValid_r),
    .pmInRange_r(pmInRange_r), .dmReq(dmReq), .dmSel(dmSel), .dmAddr(dmAddr),
    .rfDropped_r(rfDropped_r));
  rfd_ctrl_bank bank (.sys_clk(sys_clk), .ctrlWrEn(ctrlWrEn), .ctrlIdx(ctrlIdx),
    .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData), .ctrlImpl(ctrlImpl));
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Holes and reserved control places read as the undefined byte
  function automatic logic [7:0] exp_rd(logic [11:0] ad);
    return (ad < 12'h100 || (ad >= 12'hf00 && !ad[7])) ? shadow[ad] : rfd_pkg::UNDEF_BYTE;
  endfunction
  // One access at a falling edge, checked after the taking edge
  task automatic acc(logic w, logic [11:0] ad, logic [7:0] d);
    logic hole;
    hole = ad >= 12'h100 && ad < 12'hf00;
    rfReq = {!w, w, ad, d};
    #1 chk("ctrlSel", ad >= 12'hf00, ctrlSel);
    chk("ctrlRdEn", !w && ad >= 12'hf00, ctrlRdEn);
    chk("ctrlWrEn", w && ad >= 12'hf00, ctrlWrEn);
    chk("ctrlIdx", ad[7:0], ctrlIdx);
    @(negedge sys_clk);
    chk("rfRdValid_r", !w, rfRdValid_r);
    chk("rfDropped_r", w && hole, rfDropped_r);
    if (!w) chk("rfRdData_r", exp_rd(ad), rfRdData_r);
    else if (!hole) shadow[ad] = d;
    rfReq = '0;
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h506a));
    repeat (20) @(negedge sys_clk);
    srst = 0;
    chk("rfRdValid_r", 1'b0, rfRdValid_r);
    // Fill RAM and implemented control places; reserved ones never written
    for (int i = 0; i < 384; i++) acc(1, (i < 256) ? 12'(i) : 12'(i + 12'he00), 8'($urandom));
    // Random mix over RAM, hole and control, edges included
    for (int i = 0; i < 600; i++) begin
      case ($urandom % 3)
        0: a = 12'($urandom % 256);
        1: a = 12'h100 + 12'($urandom % 12'he00);
        default: a = 12'hf00 + 12'($urandom % 256);
      endcase
      if (i < 4) a = corner[i];
      acc(($urandom % 2) && !(a >= 12'hf80), a, 8'($urandom));
      acc(0, a, 8'h00);
    end
    // Write then read back to back, then a reset in mid-run
    rfReq = {1'b0, 1'b1, 12'h010, 8'h5a};
    @(negedge sys_clk);
    rfReq = {1'b1, 1'b0, 12'h010, 8'h00};
    shadow[12'h010] = 8'h5a;
    @(negedge sys_clk);
    chk("rfRdValid_r", 1'b1, rfRdValid_r);
    chk("rfRdData_r", 8'h5a, rfRdData_r);
    rfReq = '0;
    srst = 1;
    repeat (2) @(negedge sys_clk);
    chk("rfRdData_r", rfd_pkg::UNDEF_BYTE, rfRdData_r);
    chk("rfRdValid_r", 1'b0, rfRdValid_r);
    srst = 0;
    // RAM is not cleared by reset, so the byte must survive
    acc(0, 12'h010, 8'h00);
    // Program and data spaces, flash boundary at 1 KB
    foreach (pa[i]) begin
      pmReq = {1'b1, pa[i]};
      dmReq = {i[0], ~pa[i]};
      #1 chk("pmFlashSel", pa[i] < 16'h0400, pmFlashSel);
      chk("pmFlashAddr", pa[i], pmFlashAddr);
      chk("dmAddr", ~pa[i], dmAddr);
      chk("dmSel", i[0], dmSel);
      @(negedge sys_clk);
      chk("pmInRange_r", pa[i] < 16'h0400, pmInRange_r);
      chk("pmRdValid_r", 1'b1, pmRdValid_r);
      pmReq = '0;
      dmReq = '0;
      @(negedge sys_clk);
      chk("pmRdValid_r", 1'b0, pmRdValid_r);
    end
    wrap_up();
  end
endmodule // rfd_register_file_bench
`default_nettype wire

// ### hdl/rfd_pkg.sv
package rfd_pkg;
  // Register file space
  localparam int unsigned RF_ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam logic [11:0] RF_RAM_BASE = 12'h000;
  localparam logic [11:0] RF_CTRL_BASE = 12'hf00;
  localparam logic [11:0] RF_CTRL_LAST = 12'hfff;
  localparam int unsigned CTRL_IDX_W = 8;
  // Variant RAM bounds in bytes
  localparam int unsigned RAM_MIN_BYTES = 256;
  localparam int unsigned RAM_MAX_BYTES = 1024;
  // Program memory space
  localparam int unsigned PM_ADDR_W = 16;
  localparam int unsigned FLASH_MIN_BYTES = 1024;
  localparam int unsigned FLASH_MAX_BYTES = 8192;
  // Value placed on undefined reads
  localparam logic [7:0] UNDEF_BYTE = 8'hff;

  typedef enum logic [1:0] {
    RFD_RGN_RAM = 2'h0,
    RFD_RGN_HOLE = 2'h1,
    RFD_RGN_CTRL = 2'h3
  } rfd_region_type;

  // Core request towards the register file
  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [11:0] addr;
    logic [7:0] wrData;
  } rfd_req_type;

  // Program or data memory request
  typedef struct packed {
    logic rdEn;
    logic [15:0] addr;
  } rfd_mem_req_type;
endpackage

// ### hdl/rfd_ram.sv
`timescale 1ns/1ps
`default_nettype none
// General-purpose byte storage, flip-flops addressed by index
module rfd_ram #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW = 10
) (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];

  // No reset on storage; contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[addr] <= wrData; // [RL11]
    end
  end

  assign rdData = mem[addr];
endmodule // rfd_ram
`default_nettype wire

// ### hdl/rfd_register_file.sv
// Functional notes
// RL1 - Three independently selected address spaces
// RL2 - Register file spans 4096 bytes, 12-bit
// RL3 - F00H to FFFH decode as control registers
// RL4 - Reserved control reads return undefined
// RL5 - Software avoids writing reserved control locations
// RL6 - RAM starts at 000H, 256B to 1KB
// RL7 - Reads above RAM, below control: undefined
// RL8 - Writes above RAM, below control: discarded
// RL9 - Sources read, destinations written per instruction
// RL10 - Program space 64KB, flash 1-8KB low
// RL11 - RAM write stored, read returns latest
`timescale 1ns/1ps
`default_nettype none
module rfd_register_file #(
  parameter int unsigned RAM_BYTES = 256,
  parameter int unsigned FLASH_BYTES = 1024
) (
  input wire logic sys_clk,
  input wire logic srst,
  // Register file port from the core
  input wire rfd_pkg::rfd_req_type rfReq,
  output logic [7:0] rfRdData_r,
  output logic rfRdValid_r,
  // Control register bank port
  output logic ctrlSel,
  output logic ctrlWrEn,
  output logic ctrlRdEn,
  output logic [7:0] ctrlIdx,
  output logic [7:0] ctrlWrData,
  input wire logic [7:0] ctrlRdData,
  input wire logic ctrlImpl,
  // Program memory port
  input wire rfd_pkg::rfd_mem_req_type pmReq,
  output logic pmFlashSel,
  output logic [15:0] pmFlashAddr,
  output logic pmRdValid_r,
  output logic pmInRange_r,
  // Data memory port
  input wire rfd_pkg::rfd_mem_req_type dmReq,
  output logic dmSel,
  output logic [15:0] dmAddr,
  // One-cycle pulse after a write that the hole refused
  output logic rfDropped_r
);
  localparam int unsigned RAM_AW = $clog2(rfd_pkg::RAM_MAX_BYTES);
  localparam logic [11:0] RAM_TOP = 12'(RAM_BYTES);
  localparam logic [16:0] FLASH_TOP = 17'(FLASH_BYTES);

  rfd_pkg::rfd_region_type region;
  logic [7:0] ramRdData;
  logic ramWrEn;
  logic pmHit;

  // Region decode of the 12-bit register address [RL2]
  always_comb begin
    if (rfReq.addr >= rfd_pkg::RF_CTRL_BASE) begin
      region = rfd_pkg::RFD_RGN_CTRL; // [RL3]
    end else if (rfReq.addr < RAM_TOP) begin
      region = rfd_pkg::RFD_RGN_RAM; // [RL6]
    end else begin
      region = rfd_pkg::RFD_RGN_HOLE;
    end
  end

  // Holes swallow writes, so nothing stored can change [RL8]
  assign ramWrEn = rfReq.wrEn && (region == rfd_pkg::RFD_RGN_RAM); // [RL9]

  rfd_ram #(
    .DEPTH(rfd_pkg::RAM_MAX_BYTES),
    .AW(RAM_AW)
  ) uRam (
    .sys_clk(sys_clk),
    .wrEn(ramWrEn),
    .addr(rfReq.addr[RAM_AW-1:0]),
    .wrData(rfReq.wrData),
    .rdData(ramRdData)
  );

  // Control bank strobes; reserved writes passed on, left to software [RL5]
  assign ctrlSel = (region == rfd_pkg::RFD_RGN_CTRL);
  assign ctrlWrEn = ctrlSel && rfReq.wrEn;
  assign ctrlRdEn = ctrlSel && rfReq.rdEn;
  assign ctrlIdx = rfReq.addr[rfd_pkg::CTRL_IDX_W-1:0];
  assign ctrlWrData = rfReq.wrData;

  // Read data, one cycle after the source read request [RL9]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rfRdData_r <= rfd_pkg::UNDEF_BYTE;
    end else if (rfReq.rdEn) begin
      unique case (region)
        rfd_pkg::RFD_RGN_RAM: rfRdData_r <= ramRdData; // [RL11]
        rfd_pkg::RFD_RGN_CTRL: rfRdData_r <= ctrlImpl ? ctrlRdData
                                                     : rfd_pkg::UNDEF_BYTE; // [RL4]
        rfd_pkg::RFD_RGN_HOLE: rfRdData_r <= rfd_pkg::UNDEF_BYTE; // [RL7]
        default: rfRdData_r <= rfd_pkg::UNDEF_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rfRdValid_r <= 1'b0;
    end else begin
      rfRdValid_r <= rfReq.rdEn;
    end
  end

  // Flags a write that landed in the hole
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rfDropped_r <= 1'b0;
    end else begin
      rfDropped_r <= rfReq.wrEn && (region == rfd_pkg::RFD_RGN_HOLE); // [RL8]
    end
  end

  // Program space: 16-bit, only the low flash is backed [RL10]
  assign pmHit = {1'b0, pmReq.addr} < FLASH_TOP;
  assign pmFlashSel = pmReq.rdEn && pmHit; // [RL1]
  assign pmFlashAddr = pmReq.addr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pmRdValid_r <= 1'b0;
      pmInRange_r <= 1'b0;
    end else begin
      pmRdValid_r <= pmReq.rdEn;
      pmInRange_r <= pmReq.rdEn && pmHit; // [RL10]
    end
  end

  // Data-only space selected on its own strobe [RL1]
  assign dmSel = dmReq.rdEn;
  assign dmAddr = dmReq.addr;

  // Checks
  sequence s_ram_write;
    rfReq.wrEn && !rfReq.rdEn && (rfReq.addr < RAM_TOP);
  endsequence

  sequence s_same_read;
    rfReq.rdEn && !rfReq.wrEn && (rfReq.addr == $past(rfReq.addr));
  endsequence

  AST_RAM_READBACK: assert property (@(posedge sys_clk) disable iff (srst) // [RL11]
    s_ram_write ##1 s_same_read |=> rfRdData_r == $past(rfReq.wrData, 2))
    else $error("RAM read did not return the last written byte");

  AST_HOLE_NO_WRITE: assert property (@(posedge sys_clk) disable iff (srst) // [RL8]
    (rfReq.wrEn && rfReq.addr >= RAM_TOP && rfReq.addr < rfd_pkg::RF_CTRL_BASE)
      |-> !ramWrEn && !ctrlWrEn)
    else $error("Write into the hole reached storage");

  AST_HOLE_FLAG: assert property (@(posedge sys_clk) disable iff (srst) // [RL8]
    (rfReq.wrEn && region == rfd_pkg::RFD_RGN_HOLE) |=> rfDropped_r)
    else $error("Hole write not flagged");

  AST_CTRL_DECODE: assert property (@(posedge sys_clk) disable iff (srst) // [RL3]
    ctrlSel == (rfReq.addr >= rfd_pkg::RF_CTRL_BASE))
    else $error("Control region decode wrong");

  AST_CTRL_NO_RAM: assert property (@(posedge sys_clk) disable iff (srst) // [RL3]
    ctrlSel |-> !ramWrEn)
    else $error("Control access wrote RAM");

  AST_RD_VALID: assert property (@(posedge sys_clk) disable iff (srst) // [RL9]
    rfReq.rdEn |=> rfRdValid_r)
    else $error("Read answer missing");

  AST_CTRL_RD: assert property (@(posedge sys_clk) disable iff (srst) // [RL4]
    (rfReq.rdEn && ctrlSel && ctrlImpl) |=> rfRdData_r == $past(ctrlRdData))
    else $error("Control read data wrong");

  AST_PM_RANGE: assert property (@(posedge sys_clk) disable iff (srst) // [RL10]
    (pmReq.rdEn && {1'b0, pmReq.addr} >= FLASH_TOP) |-> !pmFlashSel ##1 !pmInRange_r)
    else $error("Unbacked program address selected flash");

  AST_RAM_BASE: assert property (@(posedge sys_clk) disable iff (srst) // [RL6]
    (rfReq.wrEn && rfReq.addr == rfd_pkg::RF_RAM_BASE) |-> ramWrEn)
    else $error("RAM not mapped at base");

  AST_DM_SEL: assert property (@(posedge sys_clk) disable iff (srst) // [RL1]
    dmReq.rdEn |-> dmSel && (dmAddr == dmReq.addr))
    else $error("Data space select wrong");

  sequence s_pm_backed;
    pmReq.rdEn && ({1'b0, pmReq.addr} < FLASH_TOP);
  endsequence

  // Reset must leave every answer idle, not just the read flag
  AST_RST_IDLE: assert property (@(posedge sys_clk) // [RL9]
    srst |=> (rfRdData_r == rfd_pkg::UNDEF_BYTE) && !rfRdValid_r && !rfDropped_r
      && !pmRdValid_r && !pmInRange_r)
    else $error("Outputs not idle after reset");

  AST_HOLE_READ: assert property (@(posedge sys_clk) disable iff (srst) // [RL7]
    (rfReq.rdEn && rfReq.addr >= RAM_TOP && rfReq.addr < rfd_pkg::RF_CTRL_BASE)
      |=> rfRdData_r == rfd_pkg::UNDEF_BYTE)
    else $error("Hole read returned stored data");

  AST_CTRL_RSVD_READ: assert property (@(posedge sys_clk) disable iff (srst) // [RL4]
    (rfReq.rdEn && ctrlSel && !ctrlImpl) |=> rfRdData_r == rfd_pkg::UNDEF_BYTE)
    else $error("Reserved control read not undefined byte");

  AST_CTRL_STROBES: assert property (@(posedge sys_clk) disable iff (srst) // [RL3]
    (ctrlRdEn == (rfReq.rdEn && rfReq.addr >= rfd_pkg::RF_CTRL_BASE))
      && (ctrlWrEn == (rfReq.wrEn && rfReq.addr >= rfd_pkg::RF_CTRL_BASE))
      && (ctrlIdx == rfReq.addr[rfd_pkg::CTRL_IDX_W-1:0]))
    else $error("Control strobes or index wrong");

  AST_RAM_ONLY: assert property (@(posedge sys_clk) disable iff (srst) // [RL6]
    (rfReq.wrEn && rfReq.addr < RAM_TOP) |-> ramWrEn && !ctrlWrEn && !ctrlSel)
    else $error("RAM write missed storage or hit control bank");

  AST_DROP_SRC: assert property (@(posedge sys_clk) disable iff (srst) // [RL8]
    rfDropped_r |-> $past(rfReq.wrEn) && ($past(rfReq.addr) >= RAM_TOP)
      && ($past(rfReq.addr) < rfd_pkg::RF_CTRL_BASE))
    else $error("Drop flag without a hole write");

  AST_PM_BACKED: assert property (@(posedge sys_clk) disable iff (srst) // [RL10]
    s_pm_backed |-> pmFlashSel ##1 (pmInRange_r && pmRdValid_r))
    else $error("Backed program address not selected");

  AST_PM_ADDR: assert property (@(posedge sys_clk) disable iff (srst) // [RL10]
    pmFlashAddr == pmReq.addr)
    else $error("Program address not passed on");
endmodule // rfd_register_file
`default_nettype wire
